// [rtl/ldc_cursor_ctl.sv]
`timescale 1ns/100ps
`include "ldc_defs.svh"

// Tracks the cursor position in display memory.
module ldc_cursor_ctl
    import ldc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Memory access events.
    input wire ldc_mem_evt_s mem_evt,
    // Current cursor position.
    output logic [15:0] cursor_pos
);

    // ======================================================================
    // State.
    ldc_cursor_s state_q;
    ldc_cursor_s state_d;

    // A load sets the position; any memory access moves it one on.
    always_comb begin
        state_d = state_q;
        if (mem_evt.load) begin
            state_d.pos = mem_evt.load_addr;
        end else if (mem_evt.wr || mem_evt.rd) begin
            state_d.pos = state_q.pos + 16'h0001;
        end
    end

    // Registers the position.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q.pos <= `LDC_RST_ADDR;
        end else begin
            state_q <= state_d;
        end
    end

    // Position comes straight from the register.
    assign cursor_pos = state_q.pos;

endmodule // ldc_cursor_ctl

// [rtl/ldc_defs.svh]
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// ==========================================================================
// Register offsets of the display control group.
`define LDC_OFS_MASTER_ENABLE 8'h09
`define LDC_OFS_ATTR_SELECT 8'h0a
`define LDC_OFS_BLOCK1_START_ADDR_LOW 8'h0b
`define LDC_OFS_BLOCK1_START_ADDR_HIGH 8'h0c
`define LDC_OFS_LINE_COUNT 8'h0d
// Last parameter index that the scroll command carries.
`define LDC_OFS_SCROLL_LAST 8'h14

// ==========================================================================
// Field positions.
`define LDC_BIT_ENABLE 0
`define LDC_ATTR_BLK3_HI 7
`define LDC_ATTR_BLK3_LO 6
`define LDC_ATTR_BLK2_HI 5
`define LDC_ATTR_BLK2_LO 4
`define LDC_ATTR_BLK1_HI 3
`define LDC_ATTR_BLK1_LO 2
`define LDC_ATTR_CUR_HI 1
`define LDC_ATTR_CUR_LO 0

// ==========================================================================
// Reset values.
`define LDC_RST_ENABLE 1'h0
`define LDC_RST_ATTR 8'h00
`define LDC_RST_BYTE 8'h00
`define LDC_RST_ADDR 16'h0000

// ==========================================================================
// Attribute codes.
`define LDC_ATTR_BLANK 2'h0
`define LDC_ATTR_STEADY 2'h1
`define LDC_ATTR_FLASH_A 2'h2
`define LDC_ATTR_FLASH_B 2'h3

// ==========================================================================
// Indirect command codes.
`define LDC_CMD_DISP_OFF 8'h10
`define LDC_CMD_DISP_ON 8'h11
`define LDC_CMD_SCROLL 8'h12

// ==========================================================================
// Flash timing in frames; cursor visible part is 70 percent of the period.
`define LDC_FRAME_CNT_W 6
`define LDC_CUR_ON_SLOW 6'h16
`define LDC_CUR_ON_VSLOW 6'h2d

`endif

// [rtl/ldc_display_control_regs.sv]
`timescale 1ns/100ps
`include "ldc_defs.svh"

// Summary of operation
// - Enable bit switches whole display on/off.
// - Cleared enable blanks regardless of attributes.
// - Third block attribute: blank, steady, flash.
// - Second block attribute also governs fourth block.
// - First block attribute: blank, steady, flash.
// - Cursor attribute: blank, steady, slow flashes.
// - Flashing cursor visible seventy percent.
// - Memory write re-enables cursor, advances position.
// - Memory read advances position, keeps cursor off.
// - Sixteen-bit block one start address held.
// - New start address applies on high write.
// - Line count register holds lines minus one.
// - Display switch command carries attribute byte.
// - Scroll command carries block address parameters.
// - Power save entry clears display enable.
module ldc_display_control_regs
    import ldc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Direct register access.
    input wire ldc_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Indirect commands and parameters.
    input wire ldc_cmd_req_s cmd_req,
    // Display memory events and cursor.
    input wire ldc_mem_evt_s mem_evt,
    output logic [15:0] cursor_pos,
    // Timing and mode inputs.
    input wire logic frame_tick,
    input wire logic dual_panel,
    input wire logic power_save_enter,
    // Display outputs.
    output logic display_on,
    output logic [3:0] block_visible,
    output logic cursor_visible,
    output logic [15:0] block1_start_addr,
    output logic [7:0] block1_line_count
);

    // ======================================================================
    // Functions.

    // Decodes an attribute into visibility for this phase.
    function automatic logic attr_visible(
        input ldc_attr_t attr,
        input logic ph32,
        input logic ph4
    );
        logic vis;
        vis = 1'b0;
        case (attr)
            `LDC_ATTR_BLANK: vis = 1'b0;
            `LDC_ATTR_STEADY: vis = 1'b1;
            `LDC_ATTR_FLASH_A: vis = ph32;
            `LDC_ATTR_FLASH_B: vis = ph4;
            default: vis = 1'b0;
        endcase
        return vis;
    endfunction

    // ======================================================================
    // State and helper nets.

    // Registered state of the bank.
    ldc_state_s state_q;
    // Next state.
    ldc_state_s state_d;
    // Flash phases from the frame counter.
    logic ph4;
    logic ph32;
    logic cph32;
    logic cph64;
    // Write that reaches the register array this cycle.
    logic eff_wr;
    logic [7:0] eff_addr;
    logic [7:0] eff_data;
    // Attribute fields.
    ldc_attr_t cur_attr;
    ldc_attr_t blk1_attr;
    ldc_attr_t blk2_attr;
    ldc_attr_t blk3_attr;
    // Raw visibility before the master enable.
    logic cur_raw;
    logic [3:0] blk_raw;

    // ======================================================================
    // Submodules.

    // Frame-driven flash phase generator.
    ldc_flash_gen u_flash (
        .core_clk(core_clk),
        .reset(reset),
        .frame_tick(frame_tick),
        .phase_div4(ph4),
        .phase_div32(ph32),
        .cur_phase_div32(cph32),
        .cur_phase_div64(cph64)
    );

    // Cursor position tracker.
    ldc_cursor_ctl u_cursor (
        .core_clk(core_clk),
        .reset(reset),
        .mem_evt(mem_evt),
        .cursor_pos(cursor_pos)
    );

    // ======================================================================
    // Write source selection.

    // Direct writes win; an indirect parameter goes to the register
    // that its place in the sequence selects.
    always_comb begin
        eff_wr = 1'b0;
        eff_addr = 8'h00;
        eff_data = 8'h00;
        if (reg_req.wr) begin
            // Direct register write.
            eff_wr = 1'b1;
            eff_addr = reg_req.addr;
            eff_data = reg_req.wdata;
        end else if (cmd_req.param_valid) begin
            case (state_q.ind_state)
                LDC_DISP_PARAM: begin
                    // Attribute byte of the display switch command.
                    eff_wr = 1'b1;
                    eff_addr = `LDC_OFS_ATTR_SELECT;
                    eff_data = cmd_req.data;
                end
                LDC_SCROLL_PARAM: begin
                    // Scroll parameters walk up the block registers.
                    eff_wr = 1'b1;
                    eff_addr = state_q.param_idx;
                    eff_data = cmd_req.data;
                end
                default: begin
                    // Stray parameter with no command; ignored.
                    eff_wr = 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // Next state.

    // Register writes, commands, cursor re-enable and power save.
    always_comb begin
        state_d = state_q;

        // Register array writes.
        if (eff_wr) begin
            case (eff_addr)
                `LDC_OFS_MASTER_ENABLE: begin
                    // Only bit 0 is stored.
                    state_d.enable = eff_data[`LDC_BIT_ENABLE];
                end
                `LDC_OFS_ATTR_SELECT: begin
                    // Attribute fields of all blocks and the cursor.
                    state_d.attr = eff_data;
                end
                `LDC_OFS_BLOCK1_START_ADDR_LOW: begin
                    // Low byte is staged; the active address is unchanged.
                    state_d.block1_start_addr_low = eff_data;
                end
                `LDC_OFS_BLOCK1_START_ADDR_HIGH: begin
                    // High byte commits the whole address at once.
                    state_d.block1_start_addr_active = {eff_data, state_q.block1_start_addr_low};
                end
                `LDC_OFS_LINE_COUNT: begin
                    // Lines in block one minus one.
                    state_d.line_count = eff_data;
                end
                default: begin
                    // Other offsets belong to other groups.
                    state_d.line_count = state_q.line_count;
                end
            endcase
        end

        // A memory write brings a disabled cursor back as steady.
        if (mem_evt.wr && (cur_attr == `LDC_ATTR_BLANK) &&
            !(eff_wr && (eff_addr == `LDC_OFS_ATTR_SELECT))) begin
            state_d.attr[`LDC_ATTR_CUR_HI:`LDC_ATTR_CUR_LO] =
                `LDC_ATTR_STEADY;
        end

        // Indirect command sequencer.
        case (state_q.ind_state)
            LDC_IDLE: begin
                state_d.param_idx = `LDC_OFS_SCROLL_LAST;
            end
            LDC_DISP_PARAM: begin
                // One parameter applies the pending on/off state too.
                if (cmd_req.param_valid && !reg_req.wr) begin
                    state_d.enable = state_q.disp_pending;
                    state_d.ind_state = LDC_IDLE;
                end
            end
            LDC_SCROLL_PARAM: begin
                // Parameters step from the first block register upwards.
                if (cmd_req.param_valid && !reg_req.wr) begin
                    if (state_q.param_idx == `LDC_OFS_SCROLL_LAST) begin
                        state_d.ind_state = LDC_IDLE;
                    end else begin
                        state_d.param_idx = state_q.param_idx + 8'h01;
                    end
                end
            end
            default: begin
                state_d.ind_state = LDC_IDLE;
            end
        endcase

        // A new command always restarts the sequence.
        if (cmd_req.cmd_valid) begin
            case (cmd_req.data)
                `LDC_CMD_DISP_ON: begin
                    state_d.disp_pending = 1'b1;
                    state_d.ind_state = LDC_DISP_PARAM;
                end
                `LDC_CMD_DISP_OFF: begin
                    state_d.disp_pending = 1'b0;
                    state_d.ind_state = LDC_DISP_PARAM;
                end
                `LDC_CMD_SCROLL: begin
                    state_d.param_idx = `LDC_OFS_BLOCK1_START_ADDR_LOW;
                    state_d.ind_state = LDC_SCROLL_PARAM;
                end
                default: begin
                    state_d.ind_state = LDC_IDLE;
                end
            endcase
        end

        // Power save forces the display off, over writes.
        if (power_save_enter) begin
            state_d.enable = 1'b0;
        end

        // Read data register; unmapped offsets read as zero.
        if (reg_req.rd) begin
            case (reg_req.addr)
                `LDC_OFS_MASTER_ENABLE: state_d.rdata = {7'h00, state_q.enable};
                `LDC_OFS_ATTR_SELECT: state_d.rdata = state_q.attr;
                `LDC_OFS_BLOCK1_START_ADDR_LOW: state_d.rdata = state_q.block1_start_addr_low;
                `LDC_OFS_BLOCK1_START_ADDR_HIGH: state_d.rdata = state_q.block1_start_addr_active[15:8];
                `LDC_OFS_LINE_COUNT: state_d.rdata = state_q.line_count;
                default: state_d.rdata = 8'h00;
            endcase
        end
    end

    // ======================================================================
    // State register.

    // Synchronous reset to defaults.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q.enable <= `LDC_RST_ENABLE;
            state_q.attr <= `LDC_RST_ATTR;
            state_q.block1_start_addr_low <= `LDC_RST_BYTE;
            state_q.block1_start_addr_active <= `LDC_RST_ADDR;
            state_q.line_count <= `LDC_RST_BYTE;
            state_q.rdata <= `LDC_RST_BYTE;
            state_q.disp_pending <= 1'b0;
            state_q.ind_state <= LDC_IDLE;
            state_q.param_idx <= `LDC_OFS_SCROLL_LAST;
        end else begin
            state_q <= state_d;
        end
    end

    // ======================================================================
    // Visibility decode.

    // Splits the attribute byte into its fields.
    always_comb begin
        blk3_attr = state_q.attr[`LDC_ATTR_BLK3_HI:`LDC_ATTR_BLK3_LO];
        blk2_attr = state_q.attr[`LDC_ATTR_BLK2_HI:`LDC_ATTR_BLK2_LO];
        blk1_attr = state_q.attr[`LDC_ATTR_BLK1_HI:`LDC_ATTR_BLK1_LO];
        cur_attr = state_q.attr[`LDC_ATTR_CUR_HI:`LDC_ATTR_CUR_LO];
    end

    // Per-block and cursor visibility before the master enable.
    always_comb begin
        blk_raw[0] = attr_visible(blk1_attr, ph32, ph4);
        blk_raw[1] = attr_visible(blk2_attr, ph32, ph4);
        blk_raw[2] = attr_visible(blk3_attr, ph32, ph4);
        // Fourth block exists only in dual panel drive.
        blk_raw[3] = dual_panel && blk_raw[1];
        // Cursor uses its own slower rates with 70 percent duty.
        cur_raw = attr_visible(cur_attr, cph32, cph64);
    end

    // The master enable overrides every attribute.
    always_comb begin
        display_on = state_q.enable;
        block_visible = state_q.enable ? blk_raw : 4'h0;
        cursor_visible = state_q.enable && cur_raw;
    end

    // Register-sourced outputs.
    assign reg_rdata = state_q.rdata;
    assign block1_start_addr = state_q.block1_start_addr_active;
    assign block1_line_count = state_q.line_count;

endmodule // ldc_display_control_regs

// [rtl/ldc_flash_gen.sv]
`timescale 1ns/100ps
`include "ldc_defs.svh"

// Counts frames and derives the flash phases.
module ldc_flash_gen
    import ldc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // One pulse per displayed frame.
    input wire logic frame_tick,
    // Flash phases, high while the flashing item is visible.
    output logic phase_div4,
    output logic phase_div32,
    output logic cur_phase_div32,
    output logic cur_phase_div64
);

    // ======================================================================
    // State.
    ldc_flash_s state_q;
    ldc_flash_s state_d;

    // The counter advances once per frame and wraps at 64.
    always_comb begin
        state_d = state_q;
        if (frame_tick) begin
            state_d.frame_cnt = state_q.frame_cnt + 6'h01;
        end
    end

    // Registers the counter.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q.frame_cnt <= 6'h00;
        end else begin
            state_q <= state_d;
        end
    end

    // Half-duty block phases, 70 percent cursor phases.
    always_comb begin
        phase_div4 = ~state_q.frame_cnt[1];
        phase_div32 = ~state_q.frame_cnt[4];
        cur_phase_div32 = ({1'b0, state_q.frame_cnt[4:0]}
            < `LDC_CUR_ON_SLOW);
        cur_phase_div64 = (state_q.frame_cnt < `LDC_CUR_ON_VSLOW);
    end

endmodule // ldc_flash_gen

// [rtl/ldc_pkg.sv]
package ldc_pkg;

    // ======================================================================
    // Types shared by the display control files.

    // Two-bit attribute field.
    typedef logic [1:0] ldc_attr_t;

    // Direct register access from the host.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ldc_reg_req_s;

    // Indirect command and parameter strobes from the host.
    typedef struct packed {
        logic cmd_valid;
        logic param_valid;
        logic [7:0] data;
    } ldc_cmd_req_s;

    // Display memory access events.
    typedef struct packed {
        logic wr;
        logic rd;
        logic load;
        logic [15:0] load_addr;
    } ldc_mem_evt_s;

    // Indirect parameter sequencer.
    typedef enum logic [1:0] {
        LDC_IDLE,
        LDC_DISP_PARAM,
        LDC_SCROLL_PARAM
    } ldc_ind_state_e;

    // Whole state of the register bank.
    typedef struct packed {
        logic enable;
        logic [7:0] attr;
        logic [7:0] block1_start_addr_low;
        logic [15:0] block1_start_addr_active;
        logic [7:0] line_count;
        logic [7:0] rdata;
        logic disp_pending;
        ldc_ind_state_e ind_state;
        logic [7:0] param_idx;
    } ldc_state_s;

    // Flash phase generator state.
    typedef struct packed {
        logic [5:0] frame_cnt;
    } ldc_flash_s;

    // Cursor tracker state.
    typedef struct packed {
        logic [15:0] pos;
    } ldc_cursor_s;

endpackage

// [verif/ldc_host_model.sv]
`timescale 1ns/100ps

// ==========================================================
// Host model: drives register and command strobes.
module ldc_host_model
    import ldc_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Bus toward the device.
    output ldc_reg_req_s reg_req,
    output ldc_cmd_req_s cmd_req,
    input wire logic [7:0] reg_rdata
);
    // Idle bus at time zero.
    initial begin
        reg_req = '0;
        cmd_req = '0;
    end

    // One register write; released lines are inverted.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
        #1;
    endtask

    // One register read; data taken once it has landed.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
        #1;
        d = reg_rdata;
    endtask

    // Command byte or parameter byte of the indirect path.
    task automatic send(input logic is_cmd, input logic [7:0] d);
        @(posedge core_clk);
        cmd_req <= '{is_cmd, ~is_cmd, d};
        @(posedge core_clk);
        cmd_req <= '{1'b0, 1'b0, ~d};
    endtask
endmodule // ldc_host_model

// [verif/ldc_regs_checker.sv]
`timescale 1ns/100ps
`include "ldc_defs.svh"

// ==========================================================
// Port checker of the display control group.
module ldc_regs_checker
    import ldc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Inputs.
    input wire ldc_reg_req_s reg_req,
    input wire ldc_cmd_req_s cmd_req,
    input wire ldc_mem_evt_s mem_evt,
    input wire logic frame_tick,
    input wire logic dual_panel,
    input wire logic power_save_enter,
    // Outputs.
    input wire logic [7:0] reg_rdata,
    input wire logic [15:0] cursor_pos,
    input wire logic display_on,
    input wire logic [3:0] block_visible,
    input wire logic cursor_visible,
    input wire logic [15:0] block1_start_addr,
    input wire logic [7:0] block1_line_count
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Decoded writes.
    wire wr_en = reg_req.wr && reg_req.addr == `LDC_OFS_MASTER_ENABLE;
    wire wr_hi = reg_req.wr && reg_req.addr == `LDC_OFS_BLOCK1_START_ADDR_HIGH;
    wire wr_cnt = reg_req.wr && reg_req.addr == `LDC_OFS_LINE_COUNT;
    wire quiet = !frame_tick && !reg_req.wr && !cmd_req.param_valid;

    enable_write_a: assert property (
        wr_en && !power_save_enter |=> display_on == $past(reg_req.wdata[0]))
        else $error("enable write lost");
    master_blank_a: assert property (
        !display_on |-> block_visible == 4'h0 && !cursor_visible)
        else $error("visible while off");
    block4_off_a: assert property (
        !dual_panel |-> !block_visible[3])
        else $error("block 4 shown, single panel");
    block1_start_addr_hold_a: assert property (
        !wr_hi && !cmd_req.param_valid |=> $stable(block1_start_addr))
        else $error("start address moved");
    block1_start_addr_high_a: assert property (
        wr_hi |=> block1_start_addr[15:8] == $past(reg_req.wdata))
        else $error("high byte not applied");
    line_count_a: assert property (
        wr_cnt |=> block1_line_count == $past(reg_req.wdata))
        else $error("line count not written");
    cursor_step_a: assert property (
        (mem_evt.wr || mem_evt.rd) && !mem_evt.load
        |=> cursor_pos == $past(cursor_pos) + 16'h0001)
        else $error("cursor did not advance");
    power_save_a: assert property (
        power_save_enter |=> !display_on)
        else $error("power save left display on");
    disp_cmd_a: assert property (
        cmd_req.cmd_valid && cmd_req.data == `LDC_CMD_DISP_ON
        ##1 cmd_req.param_valid && !reg_req.wr && !power_save_enter
        |=> display_on)
        else $error("switch command ignored");
    flash_hold_a: assert property (
        quiet && !power_save_enter |=> $stable(block_visible[2:0]))
        else $error("blocks moved, no frame");

    cover property (power_save_enter ##1 !display_on);
    cover property (wr_hi);
    cover property (mem_evt.wr && !cursor_visible);
endmodule // ldc_regs_checker

bind ldc_display_control_regs ldc_regs_checker chk (
    .core_clk(core_clk),
    .reset(reset),
    .reg_req(reg_req),
    .cmd_req(cmd_req),
    .mem_evt(mem_evt),
    .frame_tick(frame_tick),
    .dual_panel(dual_panel),
    .power_save_enter(power_save_enter),
    .reg_rdata(reg_rdata),
    .cursor_pos(cursor_pos),
    .display_on(display_on),
    .block_visible(block_visible),
    .cursor_visible(cursor_visible),
    .block1_start_addr(block1_start_addr),
    .block1_line_count(block1_line_count)
);

// [verif/testbench.sv]
`timescale 1ns/100ps
`include "ldc_defs.svh"

// ==========================================================
// Self-checking bench of the display control group.
module testbench;
    import ldc_pkg::*;
    // Stimulus driven by the bench.
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic frame_tick = 1'b0;
    logic dual_panel = 1'b1;
    logic power_save_enter = 1'b0;
    ldc_mem_evt_s mem_evt = '0;
    ldc_reg_req_s reg_req;
    ldc_cmd_req_s cmd_req;
    // Observed outputs.
    logic [7:0] reg_rdata, rd8, block1_line_count;
    logic [15:0] cursor_pos, block1_start_addr;
    logic display_on, cursor_visible;
    logic [3:0] block_visible;
    // Frame count as the bench expects it.
    logic [5:0] fc = 6'h00;
    int error_cnt = 0;
    int comparisons = 0;

    always #5 core_clk = ~core_clk;

    ldc_host_model host (.core_clk(core_clk), .reg_req(reg_req),
        .cmd_req(cmd_req), .reg_rdata(reg_rdata));

    ldc_display_control_regs uut (.core_clk(core_clk), .reset(reset),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .cmd_req(cmd_req),
        .mem_evt(mem_evt), .cursor_pos(cursor_pos),
        .frame_tick(frame_tick), .dual_panel(dual_panel),
        .power_save_enter(power_save_enter), .display_on(display_on),
        .block_visible(block_visible), .cursor_visible(cursor_visible),
        .block1_start_addr(block1_start_addr),
        .block1_line_count(block1_line_count));

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd_reg(a, rd8);
        chk("register read", 16'(exp), 16'(rd8));
    endtask

    // One frame pulse; the bench counter follows it.
    task automatic tick();
        @(posedge core_clk);
        frame_tick <= 1'b1;
        @(posedge core_clk);
        frame_tick <= 1'b0;
        fc = fc + 6'h01;
        #1;
    endtask

    // One memory event.
    task automatic mem(input logic w, input logic r, input logic ld,
                       input logic [15:0] a);
        @(posedge core_clk);
        mem_evt <= '{w, r, ld, a};
        @(posedge core_clk);
        mem_evt <= '{1'b0, 1'b0, 1'b0, ~a};
        #1;
    endtask

    // Expected block visibility.
    function automatic logic blk_vis(input logic [1:0] c,
                                     input logic [5:0] f);
        case (c)
            2'h0: return 1'b0;
            2'h1: return 1'b1;
            2'h2: return ~f[4];
            default: return ~f[1];
        endcase
    endfunction

    // Expected cursor visibility, 70 percent on.
    function automatic logic cur_vis(input logic [1:0] c,
                                     input logic [5:0] f);
        case (c)
            2'h0: return 1'b0;
            2'h1: return 1'b1;
            2'h2: return {1'b0, f[4:0]} < `LDC_CUR_ON_SLOW;
            default: return f < `LDC_CUR_ON_VSLOW;
        endcase
    endfunction

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        for (int a = 9; a <= 14; a++) begin
            rd_chk(8'(a), 8'h00);
        end
        host.wr_reg(8'h0e, 8'hff);
        rd_chk(8'h0e, 8'h00);
        host.wr_reg(`LDC_OFS_ATTR_SELECT, 8'h55);
        chk("blank", 16'h0, 16'({block_visible, cursor_visible}));
        host.wr_reg(`LDC_OFS_MASTER_ENABLE, 8'h01);
        chk("enable", 16'h1, 16'(display_on));
        chk("shown", 16'h1f, 16'({block_visible, cursor_visible}));
        @(posedge core_clk);
        dual_panel <= 1'b0;
        #1;
        chk("single panel", 16'h7, 16'(block_visible));
        @(posedge core_clk);
        dual_panel <= 1'b1;
        // Every attribute code over 64 frames.
        for (int c = 0; c < 4; c++) begin
            host.wr_reg(`LDC_OFS_ATTR_SELECT, {4{2'(c)}});
            for (int i = 0; i < 64; i++) begin
                chk("blocks", 16'({4{blk_vis(2'(c), fc)}}),
                    16'(block_visible));
                chk("cursor", 16'(cur_vis(2'(c), fc)),
                    16'(cursor_visible));
                tick();
            end
        end
        // Cursor tracking, cursor off.
        host.wr_reg(`LDC_OFS_ATTR_SELECT, 8'h00);
        mem(1'b0, 1'b0, 1'b1, 16'hffff);
        mem(1'b0, 1'b1, 1'b0, 16'h0000);
        chk("read step", 16'h0, cursor_pos);
        chk("cursor kept off", 16'h0, 16'(cursor_visible));
        mem(1'b1, 1'b0, 1'b0, 16'h0000);
        chk("write step", 16'h1, cursor_pos);
        chk("cursor back on", 16'h1, 16'(cursor_visible));
        rd_chk(`LDC_OFS_ATTR_SELECT, 8'h01);
        // Start address staging.
        host.wr_reg(`LDC_OFS_BLOCK1_START_ADDR_LOW, 8'h34);
        chk("old address", 16'h0, block1_start_addr);
        rd_chk(`LDC_OFS_BLOCK1_START_ADDR_LOW, 8'h34);
        host.wr_reg(`LDC_OFS_BLOCK1_START_ADDR_HIGH, 8'h12);
        chk("new address", 16'h1234, block1_start_addr);
        host.wr_reg(`LDC_OFS_LINE_COUNT, 8'hff);
        chk("lines", 16'hff, 16'(block1_line_count));
        rd_chk(`LDC_OFS_LINE_COUNT, 8'hff);
        // Indirect commands.
        host.send(1'b1, `LDC_CMD_DISP_OFF);
        host.send(1'b0, 8'h5a);
        #1;
        chk("switch off", 16'h0, 16'(display_on));
        rd_chk(`LDC_OFS_ATTR_SELECT, 8'h5a);
        host.send(1'b1, `LDC_CMD_DISP_ON);
        host.send(1'b0, 8'h15);
        #1;
        chk("switch on", 16'h1, 16'(display_on));
        host.send(1'b1, `LDC_CMD_SCROLL);
        for (int i = 0; i < 10; i++) begin
            host.send(1'b0, 8'h70 + 8'(i));
        end
        #1;
        chk("scroll address", 16'h7170, block1_start_addr);
        host.send(1'b0, 8'hee);
        #1;
        chk("scroll lines", 16'h72, 16'(block1_line_count));
        // Power save drops the enable.
        @(posedge core_clk);
        power_save_enter <= 1'b1;
        @(posedge core_clk);
        power_save_enter <= 1'b0;
        #1;
        chk("power save", 16'h0, 16'(display_on));
        rd_chk(`LDC_OFS_MASTER_ENABLE, 8'h00);
        report_and_stop();
    end
endmodule // testbench
